// ==== verilog/scr_pkg.sv ====
// Package: register map, field layout and timing for the serial clock and receive path
package scr_pkg;
  // ==================== Register offsets
  localparam logic [7:0] SCR_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SCR_BAUD_OFF   = 8'h04;
  localparam logic [7:0] SCR_TIMER_OFF  = 8'h08;
  localparam logic [7:0] SCR_DATA_OFF   = 8'h0c;
  localparam logic [7:0] SCR_STATUS_OFF = 8'h10;
  // ==================== Reset values
  localparam logic [8:0]  SCR_CTRL_RST  = 9'h100;
  localparam logic [10:0] SCR_BAUD_RST  = 11'h001;
  localparam logic [7:0]  SCR_TIMER_RST = 8'h01;
  // ==================== Receive counter taps
  localparam logic [3:0] SCR_SAMPLE_FIRST = 4'h6;  // 7th count
  localparam logic [3:0] SCR_SAMPLE_LAST  = 4'h8;  // 9th count
  localparam logic [3:0] SCR_COUNT_LAST   = 4'hf;
  // ==================== External clock limits
  localparam int SCR_CLK_NS          = 10;
  localparam int SCR_UART_EXT_MIN_NS = 4 * SCR_CLK_NS;
  localparam int SCR_IO_EXT_MIN_NS   = 16 * SCR_CLK_NS;
  localparam int SCR_UART_EXT_MIN_CY = (SCR_UART_EXT_MIN_NS + SCR_CLK_NS - 1) / SCR_CLK_NS;
  localparam int SCR_IO_EXT_MIN_CY   = SCR_IO_EXT_MIN_NS / SCR_CLK_NS + 1;
  // ==================== Enumerations
  typedef enum logic [1:0] {
    SCR_SRC_BAUD  = 2'b00,
    SCR_SRC_HALF  = 2'b01,
    SCR_SRC_TIMER = 2'b10,
    SCR_SRC_EXT   = 2'b11
  } scr_src_t;
  typedef enum logic [1:0] {
    SCR_LEN_7 = 2'b00,
    SCR_LEN_8 = 2'b01,
    SCR_LEN_9 = 2'b10
  } scr_len_t;
  typedef enum logic [1:0] {
    SCR_RX_IDLE  = 2'b00,
    SCR_RX_START = 2'b01,
    SCR_RX_DATA  = 2'b10,
    SCR_RX_STOP  = 2'b11
  } scr_rx_state_t;
  // ==================== Register layouts
  typedef struct packed {
    logic     rx_enable;
    scr_len_t char_len;
    logic     wakeup_enable;
    scr_src_t serial_clock_source;
    logic     clock_edge_select;
    logic     clock_direction_select;
    logic     clocked_io_mode;
  } scr_ctrl_t;
  typedef struct packed {
    logic [1:0] prescaler_clock_select;
    logic       fractional_divide_enable;
    logic [3:0] fraction_numerator;
    logic [3:0] integer_divisor;
  } scr_baud_t;
  typedef struct packed {
    logic       ninth_received_bit;
    logic [7:0] data;
  } scr_char_t;
endpackage

// ==== verilog/scr_serial_rx.sv ====
// Serial clock selection, bit timing and double-buffered receive path
// Function
// - Async external clock: baud is clock/16
// - Clocked external clock: bit rate equals clock
// - Timer source unavailable in clocked mode
// - Timer baud: prescaler/(compare*2*16)
// - Direction 0: pin output, baud/2
// - Direction 1: pin input, edge selectable
// - Async source field picks four clocks
// - 4-bit receive counter, 16 counts/bit
// - Vote over counts 7, 8, 9
// - Valid start bit; vote start/data/stop
// - Output clock: sample on rising edge
// - Input clock: edge chosen by select
// - Full character moves to holding buffer
// - Overrun drops new, keeps holding
// - Ninth bit: parity or address flag
// - Wake-up: interrupt on address flag
// - Transmit tick every 16 base clocks, async mode only
// - Clocked mode double buffer full-duplex
// - Integer or fractional baud divide
// - Clocked mode: integer divide only
//
// The implementer's own choices: the address map and the APB register port.
module scr_serial_rx
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        receive_data_pin,
  input  wire logic        shift_clock_pin_i,
  output logic             shift_clock_pin_o,
  output logic             shift_clock_pin_oe,
  // Events
  output logic             receive_done_irq,
  output logic             transmit_bit_tick
);
  // ==================== Registers
  scr_ctrl_t     ctrl_reg;
  scr_baud_t     baud_reg;
  logic [7:0]    timer_compare_value_reg;
  scr_char_t     receive_holding_buffer_reg;
  logic          full_reg, overrun_reg, framing_reg;
  logic [31:0]   prdata_reg;
  logic [2:0]    rx_sync_reg, sclk_sync_reg;
  logic [5:0]    pre_cnt_reg;
  logic [3:0]    baud_cnt_reg, frac_acc_reg;
  logic          baud_long_reg;
  logic [7:0]    tmr_cnt_reg;
  logic          tmr_ff_reg, half_reg, io_clk_reg;
  logic [3:0]    tx_cnt_reg, rx_cnt_reg, bit_idx_reg;
  scr_rx_state_t rx_state_reg;
  logic [1:0]    votes_reg;
  logic [8:0]    shift_reg;
  logic          irq_reg;

  // ==================== APB decode
  wire setup     = psel & ~penable;
  wire access    = psel & penable;
  wire hit_ctrl  = paddr == SCR_CTRL_OFF;
  wire hit_baud  = paddr == SCR_BAUD_OFF;
  wire hit_timer = paddr == SCR_TIMER_OFF;
  wire hit_data  = paddr == SCR_DATA_OFF;
  wire hit_stat  = paddr == SCR_STATUS_OFF;
  wire mapped    = hit_ctrl | hit_baud | hit_timer | hit_data | hit_stat;
  wire wr        = access & pwrite & mapped;
  wire rd_data   = access & ~pwrite & hit_data;
  wire [31:0] rd_mux =
      hit_ctrl  ? {23'h0, ctrl_reg} :
      hit_baud  ? {21'h0, baud_reg} :
      hit_timer ? {24'h0, timer_compare_value_reg} :
      hit_data  ? {23'h0, receive_holding_buffer_reg} :
      hit_stat  ? {29'h0, framing_reg, overrun_reg, full_reg} : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_reg;

  // ==================== Mode decode
  wire clk_io  = ctrl_reg.clocked_io_mode;
  wire ext_in  = ctrl_reg.clock_direction_select;
  wire edge_sel = ctrl_reg.clock_edge_select;

  // ==================== Prescaler and baud generator
  function automatic logic [3:0] div_n(input logic [3:0] n);
    div_n = (n == 4'h0) ? 4'hf : n - 4'h1;  // Code 0 means 16
  endfunction
  wire pre_tick =
      (baud_reg.prescaler_clock_select == 2'b00) ? 1'b1 :
      (baud_reg.prescaler_clock_select == 2'b01) ? (pre_cnt_reg[1:0] == 2'b11) :
      (baud_reg.prescaler_clock_select == 2'b10) ? (pre_cnt_reg[3:0] == 4'hf) :
                                                   (pre_cnt_reg == 6'h3f);
  wire frac_on = baud_reg.fractional_divide_enable & ~clk_io;
  wire [3:0] baud_top = div_n(baud_reg.integer_divisor);
  wire baud_tick = pre_tick & (baud_cnt_reg == baud_top) & ~baud_long_reg;
  wire [4:0] frac_sum = {1'b0, frac_acc_reg} + {1'b0, 4'h0 - baud_reg.fraction_numerator};
  // Timer trigger flop toggles on each compare match
  wire tmr_match = pre_tick & (tmr_cnt_reg == timer_compare_value_reg - 8'h01);
  wire tmr_tick  = tmr_match & ~tmr_ff_reg;

  // ==================== External clock edges
  wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire rx_in     = rx_sync_reg[1];
  wire io_edge   = ext_in ? (edge_sel ? sclk_fall : sclk_rise)
                          : (baud_tick & ~io_clk_reg);

  // ==================== Base serial clock
  wire base_serial_clock =
      clk_io ? io_edge :
      (ctrl_reg.serial_clock_source == SCR_SRC_BAUD)  ? baud_tick :
      (ctrl_reg.serial_clock_source == SCR_SRC_HALF)  ? half_reg :
      (ctrl_reg.serial_clock_source == SCR_SRC_TIMER) ? tmr_tick :
                                                        sclk_rise;

  // ==================== Receive decode
  wire [3:0] last_bit = (ctrl_reg.char_len == SCR_LEN_7) ? 4'h6 :
                        (ctrl_reg.char_len == SCR_LEN_8) ? 4'h7 : 4'h8;
  wire [1:0] vote_sum = votes_reg + {1'b0, rx_in};
  wire vote  = vote_sum[1];
  wire in_win = rx_cnt_reg >= SCR_SAMPLE_FIRST && rx_cnt_reg <= SCR_SAMPLE_LAST;
  wire decide = base_serial_clock & ~clk_io & (rx_cnt_reg == SCR_SAMPLE_LAST);
  wire uart_done = decide & (rx_state_reg == SCR_RX_STOP);
  wire io_done = base_serial_clock & clk_io & ctrl_reg.rx_enable & (bit_idx_reg == 4'h7);
  wire [8:0] uart_word = (ctrl_reg.char_len == SCR_LEN_7) ? {2'b00, shift_reg[8:2]} :
                         (ctrl_reg.char_len == SCR_LEN_8) ? {1'b0, shift_reg[8:1]} :
                                                            shift_reg;
  wire [8:0] io_word = {1'b0, rx_in, shift_reg[8:2]};
  wire wake_block = ctrl_reg.wakeup_enable & (ctrl_reg.char_len == SCR_LEN_9) & ~shift_reg[8];
  wire char_done = (uart_done & ~wake_block) | io_done;
  wire loads     = char_done & ~full_reg;
  wire overrun   = char_done & full_reg;

  // ==================== Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg                <= scr_ctrl_t'(SCR_CTRL_RST);
      baud_reg                <= scr_baud_t'(SCR_BAUD_RST);
      timer_compare_value_reg <= SCR_TIMER_RST;
      prdata_reg              <= 32'h0;
    end
    else
    begin
      if (wr && hit_ctrl) ctrl_reg <= scr_ctrl_t'(pwdata[8:0]);
      if (wr && hit_baud) baud_reg <= scr_baud_t'(pwdata[10:0]);
      if (wr && hit_timer) timer_compare_value_reg <= pwdata[7:0];
      if (setup) prdata_reg <= rd_mux;
    end
  end

  // ==================== Holding buffer and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_holding_buffer_reg <= '0;
      full_reg    <= 1'b0;
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      if (loads) receive_holding_buffer_reg <= clk_io ? io_word : uart_word;
      // Set beats clear in the same cycle
      full_reg    <= loads | (full_reg & ~rd_data);
      overrun_reg <= overrun | (overrun_reg & ~(wr && hit_stat && pwdata[1]));
      framing_reg <= (uart_done & ~vote) | (framing_reg & ~(wr && hit_stat && pwdata[2]));
      irq_reg     <= char_done;
    end
  end
  assign receive_done_irq = irq_reg;

  // ==================== Clock generation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sync_reg   <= 3'b111;
      sclk_sync_reg <= 3'b000;
      pre_cnt_reg   <= 6'h0;
      baud_cnt_reg  <= 4'h0;
      frac_acc_reg  <= 4'h0;
      baud_long_reg <= 1'b0;
      tmr_cnt_reg   <= 8'h0;
      tmr_ff_reg    <= 1'b0;
      half_reg      <= 1'b0;
      io_clk_reg    <= 1'b0;
      tx_cnt_reg    <= 4'h0;
    end
    else
    begin
      rx_sync_reg   <= {rx_sync_reg[1:0], receive_data_pin};
      sclk_sync_reg <= {sclk_sync_reg[1:0], shift_clock_pin_i};
      pre_cnt_reg   <= pre_cnt_reg + 6'h1;
      half_reg      <= ~half_reg;
      if (pre_tick)
      begin
        // Fractional period: one extra input clock on carry cycles
        if (baud_cnt_reg == baud_top && baud_long_reg) baud_long_reg <= 1'b0;
        else if (baud_cnt_reg == baud_top)
        begin
          baud_cnt_reg <= 4'h0;
          if (frac_on)
          begin
            frac_acc_reg  <= frac_sum[3:0];
            baud_long_reg <= frac_sum[4];
          end
        end
        else baud_cnt_reg <= baud_cnt_reg + 4'h1;
        tmr_cnt_reg <= tmr_match ? 8'h0 : tmr_cnt_reg + 8'h1;
      end
      if (tmr_match) tmr_ff_reg <= ~tmr_ff_reg;
      if (baud_tick) io_clk_reg <= ~io_clk_reg;
      if (base_serial_clock) tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
  end
  assign shift_clock_pin_oe = clk_io & ~ext_in;
  assign shift_clock_pin_o  = io_clk_reg & shift_clock_pin_oe;
  assign transmit_bit_tick  = base_serial_clock & ~clk_io & (tx_cnt_reg == SCR_COUNT_LAST);

  // ==================== Receive controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg <= SCR_RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      bit_idx_reg  <= 4'h0;
      votes_reg    <= 2'b00;
      shift_reg    <= 9'h0;
    end
    else if (!ctrl_reg.rx_enable)
    begin
      rx_state_reg <= SCR_RX_IDLE;
      bit_idx_reg  <= 4'h0;
    end
    else if (clk_io)
    begin
      if (base_serial_clock)
      begin
        shift_reg   <= {rx_in, shift_reg[8:1]};
        bit_idx_reg <= (bit_idx_reg == 4'h7) ? 4'h0 : bit_idx_reg + 4'h1;
      end
    end
    else if (base_serial_clock)
    begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      if (in_win) votes_reg <= (rx_cnt_reg == SCR_SAMPLE_FIRST) ? {1'b0, rx_in} : vote_sum;
      case (rx_state_reg)
        SCR_RX_IDLE:
        begin
          rx_cnt_reg <= 4'h0;
          bit_idx_reg <= 4'h0;
          if (!rx_in)
          begin
            rx_state_reg <= SCR_RX_START;
            rx_cnt_reg   <= 4'h1;
          end
        end
        SCR_RX_START:
          if (rx_cnt_reg == SCR_SAMPLE_LAST && vote) rx_state_reg <= SCR_RX_IDLE;
          else if (rx_cnt_reg == SCR_COUNT_LAST)
          begin
            rx_state_reg <= SCR_RX_DATA;
            bit_idx_reg  <= 4'h0;
          end
        SCR_RX_DATA:
        begin
          if (rx_cnt_reg == SCR_SAMPLE_LAST) shift_reg <= {vote, shift_reg[8:1]};
          if (rx_cnt_reg == SCR_COUNT_LAST)
          begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg == last_bit) rx_state_reg <= SCR_RX_STOP;
          end
        end
        SCR_RX_STOP:
          if (rx_cnt_reg == SCR_SAMPLE_LAST)
          begin
            rx_state_reg <= SCR_RX_IDLE;
            bit_idx_reg  <= 4'h0;  // Clocked mode must start from bit zero
          end
        default: rx_state_reg <= SCR_RX_IDLE;
      endcase
    end
  end

  // ==================== Assertions
  sequence s_char_done;
    char_done;
  endsequence
  a_irq_follows_done: assert property (@(posedge pclk) disable iff (!presetn)
    s_char_done |=> receive_done_irq)
    else $error("receive interrupt missing after character");
  a_overrun_keeps_buf: assert property (@(posedge pclk) disable iff (!presetn)
    overrun |=> $stable(receive_holding_buffer_reg) && overrun_reg)
    else $error("overrun changed holding buffer");
  a_load_sets_full: assert property (@(posedge pclk) disable iff (!presetn)
    loads |=> full_reg)
    else $error("load did not set full");
  a_pin_dir_io: assert property (@(posedge pclk) disable iff (!presetn)
    shift_clock_pin_oe |-> clk_io && !ext_in)
    else $error("shift clock driven outside output mode");
  a_timer_not_io: assert property (@(posedge pclk) disable iff (!presetn)
    clk_io && !ext_in |-> base_serial_clock == io_edge)
    else $error("clocked mode took another source");
  a_tx_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    transmit_bit_tick |-> tx_cnt_reg == 4'hf && base_serial_clock)
    else $error("transmit tick off its count");
  a_false_start: assert property (@(posedge pclk) disable iff (!presetn)
    decide && rx_state_reg == SCR_RX_START && vote && ctrl_reg.rx_enable
      |=> rx_state_reg == SCR_RX_IDLE)
    else $error("false start accepted");
  a_wake_block: assert property (@(posedge pclk) disable iff (!presetn)
    uart_done && wake_block && !io_done |=> !receive_done_irq)
    else $error("data character woke receiver");
  a_frac_off_io: assert property (@(posedge pclk) disable iff (!presetn)
    clk_io |=> !baud_long_reg || $past(baud_long_reg))
    else $error("fraction used in clocked mode");
  a_framing_flag: assert property (@(posedge pclk) disable iff (!presetn)
    uart_done && !vote |=> framing_reg)
    else $error("bad stop bit not flagged");

  // ==================== Assertions: bit timing and sampling
  sequence s_data_decide;
    decide && rx_state_reg == SCR_RX_DATA && ctrl_reg.rx_enable;
  endsequence
  sequence s_ext_rise_sample;
    clk_io && ext_in && !edge_sel && ctrl_reg.rx_enable && sclk_rise;
  endsequence
  a_rx_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    base_serial_clock && !clk_io && ctrl_reg.rx_enable && rx_state_reg != SCR_RX_IDLE
      |=> rx_cnt_reg == $past(rx_cnt_reg) + 4'h1)
    else $error("receive counter skipped a count");
  a_vote_data: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_decide |=> shift_reg[8] == $past(vote))
    else $error("data bit not taken from vote");
  a_data_order: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_decide |=> shift_reg[7:0] == $past(shift_reg[8:1]))
    else $error("first-stage buffer lost a bit");
  a_io_ext_rise: assert property (@(posedge pclk) disable iff (!presetn)
    s_ext_rise_sample |=> shift_reg[8] == $past(rx_in))
    else $error("rising shift clock edge not sampled");
  a_io_ext_fall: assert property (@(posedge pclk) disable iff (!presetn)
    clk_io && ext_in && edge_sel && ctrl_reg.rx_enable && sclk_rise
      |=> $stable(shift_reg))
    else $error("rising edge sampled in falling mode");
  a_io_out_rise: assert property (@(posedge pclk) disable iff (!presetn)
    clk_io && !ext_in && base_serial_clock |=> io_clk_reg)
    else $error("output clock sample not on rising edge");
  a_pin_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
    !shift_clock_pin_oe |-> !shift_clock_pin_o)
    else $error("shift clock output active while released");
  a_ninth_bit: assert property (@(posedge pclk) disable iff (!presetn)
    loads && !clk_io && ctrl_reg.char_len == SCR_LEN_9
      |=> receive_holding_buffer_reg.ninth_received_bit == $past(shift_reg[8]))
    else $error("ninth bit not stored");
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data && !loads |=> !full_reg)
    else $error("read left holding buffer full");
  a_idle_no_start: assert property (@(posedge pclk) disable iff (!presetn)
    rx_state_reg == SCR_RX_IDLE && base_serial_clock && !clk_io && ctrl_reg.rx_enable && rx_in
      |=> rx_state_reg == SCR_RX_IDLE)
    else $error("idle line started a character");
  a_tx_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    transmit_bit_tick |=> tx_cnt_reg == 4'h0)
    else $error("transmit counter did not wrap");
  a_timer_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_tick |=> !tmr_tick)
    else $error("timer trigger ticked twice in a row");
endmodule // scr_serial_rx

// ==== bench/scr_remote_dev.sv ====
// Remote serial device model: UART sender and shift clock source
module scr_remote_dev (
  // Clock
  input  wire logic pclk,
  // Serial lines
  output logic      line,
  output logic      sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_run;
  logic ph;
  initial
  begin
    line = 1'b1;
    sclk = 1'b1;
    ext_run = 1'b0;
    ph = 1'b0;
  end
  // ==================== Free-running external clock, 4 pclk period
  always @(posedge pclk)
    if (ext_run)
    begin
      ph <= ~ph;
      if (ph) sclk <= ~sclk;
    end
  // ==================== UART frame, LSB first, idle high
  task automatic send(input logic [8:0] v, input int nb, input int bc);
    @(posedge pclk);
    line <= 1'b0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < nb; i++)
    begin
      line <= v[i];
      repeat (bc) @(posedge pclk);
    end
    line <= 1'b1;
    repeat (bc) @(posedge pclk);
  endtask
  task automatic glitch(input int n);
    line <= 1'b0;
    repeat (n) @(posedge pclk);
    line <= 1'b1;
  endtask
  // ==================== Clocked frame, data moves on the unsampled edge
  task automatic io_send(input logic [7:0] v, input logic fe, input int h);
    for (int i = 0; i < 8; i++)
    begin
      sclk <= fe;
      line <= v[i];
      repeat (h) @(posedge pclk);
      sclk <= ~fe;
      repeat (h) @(posedge pclk);
    end
    line <= ~v[7];
  endtask
endmodule  // scr_remote_dev

// ==== bench/tb_serial_clock_and_receive_path.sv ====
// Self-checking bench for the serial clock and receive path
module tb_serial_clock_and_receive_path
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==================== Signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sclk_o, sclk_oe, irq, tick, rxd, sclk_r;
  wire         sclk_i;
  logic [8:0]  va, vb;
  logic [65:0] exq[$];
  logic [65:0] note;
  int          n_fail, n_checks, g;
  scr_src_t    srcs[5] = '{SCR_SRC_HALF, SCR_SRC_BAUD, SCR_SRC_BAUD, SCR_SRC_TIMER, SCR_SRC_EXT};
  logic [31:0] bauds[5] = '{32'h001, 32'h003, 32'h182, 32'h001, 32'h001};
  int          bits[5] = '{32, 48, 40, 64, 64};
  assign sclk_i = sclk_oe ? sclk_o : sclk_r;
  scr_serial_rx u_scr_serial_rx (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_data_pin(rxd), .shift_clock_pin_i(sclk_i), .shift_clock_pin_o(sclk_o),
    .shift_clock_pin_oe(sclk_oe), .receive_done_irq(irq), .transmit_bit_tick(tick)
  );
  scr_remote_dev rem (.pclk(pclk), .line(rxd), .sclk(sclk_r));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==================== Checking and reporting
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail_out();
    n_fail++;
    wrap_up();
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0)
    begin
      note = exq.pop_front();
      chk($sformatf("read %h", paddr), note[65:33] & note[32:0], {pslverr, prdata} & note[32:0]);
    end
  initial
  begin
    repeat (90000) @(posedge pclk);
    fail_out();
  end
  // ==================== APB master and helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exq.push_back({e, m});
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_out();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask
  function automatic logic [31:0] ctl(scr_src_t s, scr_len_t l, logic w, logic [2:0] io);
    scr_ctrl_t c;
    c = '{1'b1, l, w, s, io[2], io[1], io[0]};
    return 32'(c);
  endfunction
  task automatic wait_irq(input int lim, input logic ei);
    int k;
    k = 0;
    @(negedge pclk);
    while (irq !== 1'b1 && k < lim)
    begin
      @(negedge pclk);
      k++;
    end
    chk("receive irq", {32'h0, ei}, {32'h0, k < lim});
    if (ei && k >= lim) fail_out();
    @(posedge pclk);
  endtask
  task automatic rx_char(input logic [8:0] v, input int nb, input int bc, input logic ei);
    fork
      rem.send(v, nb, bc);
      wait_irq(13 * bc, ei);
    join
  endtask
  // ==================== Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    n_checks = 0;
    g = $urandom(88594);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SCR_CTRL_OFF, 32'(SCR_CTRL_RST), 32'h1ff);
    rd(SCR_BAUD_OFF, 32'(SCR_BAUD_RST), 32'h7ff);
    rd(SCR_TIMER_OFF, 32'(SCR_TIMER_RST), 32'hff);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    $display("test registers done");
    wr(SCR_TIMER_OFF, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      va = 9'($urandom_range(255));
      wr(SCR_BAUD_OFF, bauds[i]);
      wr(SCR_CTRL_OFF, ctl(srcs[i], SCR_LEN_8, 1'b0, 3'b000));
      rem.ext_run <= (srcs[i] == SCR_SRC_EXT);
      rx_char(va, 8, bits[i], 1'b1);
      rd(SCR_DATA_OFF, {24'h0, va[7:0]}, 32'hff);
    end
    rem.ext_run <= 1'b0;
    $display("test sources done");
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_HALF, SCR_LEN_8, 1'b0, 3'b000));
    g = 0;
    do
    begin
      @(negedge pclk);
      g++;
    end
    while (tick !== 1'b1 && g < 100);
    if (g >= 100) fail_out();
    g = 0;
    do
    begin
      @(negedge pclk);
      g++;
    end
    while (tick !== 1'b1 && g < 100);
    chk("tick gap", 33'h20, 33'(g));
    @(posedge pclk);
    va = 9'($urandom_range(127));
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_HALF, SCR_LEN_7, 1'b0, 3'b000));
    rx_char(va, 7, 32, 1'b1);
    rd(SCR_DATA_OFF, {25'h0, va[6:0]}, 32'h7f);
    va = 9'($urandom_range(255)) | 9'h100;
    vb = 9'($urandom_range(255));
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_HALF, SCR_LEN_9, 1'b0, 3'b000));
    rx_char(va, 9, 32, 1'b1);
    rd(SCR_DATA_OFF, {23'h0, va}, 32'h1ff);
    fork
      begin
        rem.send(va, 9, 32);
        rem.send(vb, 9, 32);
      end
      begin
        wait_irq(500, 1'b1);
        wait_irq(500, 1'b1);
      end
    join
    rd(SCR_DATA_OFF, {23'h0, va}, 32'h1ff);
    rd(SCR_STATUS_OFF, 32'h2, 32'h3);
    wr(SCR_STATUS_OFF, 32'h2);
    rd(SCR_STATUS_OFF, 32'h0, 32'h3);
    $display("test lengths and overrun done");
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_HALF, SCR_LEN_9, 1'b1, 3'b000));
    rx_char(vb & 9'h0ff, 9, 32, 1'b0);
    rx_char(vb | 9'h100, 9, 32, 1'b1);
    rd(SCR_DATA_OFF, {23'h0, vb | 9'h100}, 32'h1ff);
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_HALF, SCR_LEN_8, 1'b0, 3'b000));
    rem.glitch(4);
    wait_irq(600, 1'b0);
    rd(SCR_STATUS_OFF, 32'h0, 32'h7);
    $display("test wakeup and false start done");
    for (int e = 0; e < 2; e++)
    begin
      va = 9'($urandom_range(255));
      rem.sclk <= ~e[0];
      repeat (4) @(posedge pclk);
      wr(SCR_CTRL_OFF, ctl(SCR_SRC_BAUD, SCR_LEN_8, 1'b0, {e[0], 2'b11}));
      @(negedge pclk);
      chk("pin enable", 33'h0, {32'h0, sclk_oe});
      @(posedge pclk);
      fork
        rem.io_send(va[7:0], e[0], 20);
        wait_irq(1000, 1'b1);
      join
      rd(SCR_DATA_OFF, {24'h0, va[7:0]}, 32'hff);
    end
    wr(SCR_CTRL_OFF, ctl(SCR_SRC_BAUD, SCR_LEN_8, 1'b0, 3'b001));
    @(negedge pclk);
    chk("pin enable", 33'h1, {32'h0, sclk_oe});
    va[0] = sclk_o;
    @(negedge pclk);
    chk("pin clock", {32'h0, ~va[0]}, {32'h0, sclk_o});
    $display("test clocked mode done");
    wrap_up();
  end
endmodule  // tb_serial_clock_and_receive_path
